// >>> core/awsp_pkg.sv
// Constants and types for the arbitrary waveform store and playback block
package awsp_pkg;
   localparam int ADDR_W = 14;
   localparam int DAC_W = 12;
   localparam logic [13:0] LEN_MIN = 14'h0008;
   localparam logic [13:0] LEN_MAX = 14'h3e80;
   localparam logic [11:0] DAC_MID = 12'h800;
   localparam logic [11:0] BIN_POS_MAX = 12'h7ff;
   localparam logic [11:0] BIN_NEG_MIN = 12'h801;
   localparam logic [31:0] NCO_STEP_RST = 32'h0000_0000;
   localparam logic [31:0] CYC_RST = 32'h0000_0001;
   localparam int N_BUILTIN = 5;
   localparam int N_USER = 4;
   // Reference half period in clocks
   localparam int REF_FREQ_MHZ = 10;
   localparam int CLK_FREQ_MHZ = 100;
   localparam int REF_HALF = CLK_FREQ_MHZ / (2 * REF_FREQ_MHZ);
   localparam logic [2:0] REF_HALF_M1 = 3'(REF_HALF - 1);
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LEN = 8'h04;
   localparam logic [7:0] REG_STEP = 8'h08;
   localparam logic [7:0] REG_PHASE = 8'h0c;
   localparam logic [7:0] REG_CYC = 8'h10;
   localparam logic [7:0] REG_WADDR = 8'h14;
   localparam logic [7:0] REG_WDATA = 8'h18;
   localparam logic [7:0] REG_CMD = 8'h1c;
   localparam logic [7:0] REG_STAT = 8'h20;
   // Control fields
   localparam int C_USER = 0;
   localparam int C_BURST = 1;
   localparam int C_BORD = 2;
   localparam int C_FMT = 3;
   localparam int C_BPDRV = 4;
   localparam int C_LOCK = 5;
   localparam int C_SRC_LO = 8;
   localparam int C_EVT_LO = 12;
   localparam int C_LINE_LO = 16;
   // Command bits
   localparam int K_ZERO = 0;
   localparam int K_TRIG = 1;
   localparam int K_COPY = 2;
   localparam int K_SETUP = 3;
   localparam int K_SLOT_LO = 4;
   // Event sources
   localparam logic [1:0] EVT_IMM = 2'h0;
   localparam logic [1:0] EVT_EXT = 2'h1;
   localparam logic [1:0] EVT_BP = 2'h2;
   localparam logic [1:0] EVT_SW = 2'h3;
   typedef enum logic [1:0] {AWSP_IDLE, AWSP_RUN, AWSP_COPY} awsp_mode_t;
endpackage

// >>> core/awsp_core.sv
// Arbitrary waveform store and playback with burst, trigger and phase lock
module awsp_core #(
   parameter int DEPTH = 16000,
   parameter int BP_LINES = 8
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic ext_trigger_in, // External trigger pin
   input wire logic [BP_LINES-1:0] bp_trigger_in, // Backplane lines, ground true
   output logic [BP_LINES-1:0] bp_trigger_out, // Backplane drive level
   output logic [BP_LINES-1:0] bp_trigger_oe, // Backplane drive enable
   output logic ext_trigger_out, // Outgoing trigger pulse
   input wire logic reference_clock_input, // 10 MHz reference in
   output logic reference_clock_output, // 10 MHz reference out
   output logic ref_locked, // Locked to reference
   output logic [11:0] dac_code // DAC sample
);
   localparam int LW = $clog2(BP_LINES);
   typedef struct packed {
      logic awready, wready, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic aw_got, w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [31:0] ctrl, step, phase_off, cyc, waddr;
      logic [13:0] len;
      logic [31:0] acc;
      logic [31:0] cyc_left;
      logic bursting;
      awsp_pkg::awsp_mode_t mode;
      logic [13:0] cp_idx;
      logic [1:0] cp_slot;
      logic [1:0] ext_s, ref_s;
      logic [BP_LINES-1:0] bp_s0, bp_s1, bp_prev;
      logic ext_prev, ref_prev, locked;
      logic [2:0] ref_cnt;
      logic ref_out;
      logic [3:0] pulse;
      logic [BP_LINES-1:0] bp_oe;
      logic [11:0] dac;
      logic [11:0] wr_code;
      logic [13:0] wr_idx;
      logic wr_en;
   } awsp_state_t;
   awsp_state_t st, next_st;
   // Waveform memories
   logic [11:0] stage_mem [DEPTH];
   logic [11:0] user_mem [awsp_pkg::N_USER][DEPTH];
   logic [13:0] user_len [awsp_pkg::N_USER];
   logic [13:0] rd_idx;
   logic [11:0] rd_stage, rd_user, rd_built, sample_code;
   logic [3:0] src;
   logic [13:0] play_len;
   logic [45:0] prod;
   logic [31:0] ph;
   assign src = st.ctrl[awsp_pkg::C_SRC_LO +: 4];
   // Built-in records from the index
   function automatic logic [11:0] builtin(input logic [2:0] sel, input logic [13:0] i);
      logic [11:0] r;
      r = 12'h000;
      unique case (sel)
         3'h0: r = i[13] ? ~{i[12:2], 1'b0} : {i[12:2], 1'b0};
         3'h1: r = {i[13:2]};
         3'h2: r = ~{i[13:2]};
         3'h3: r = (i < 14'h1f40) ? 12'hfff : 12'h000;
         3'h4: r = i[13] ? 12'h000 : {i[12:2], 1'b0};
         default: r = awsp_pkg::DAC_MID;
      endcase
      return r;
   endfunction
   always_comb begin
      play_len = awsp_pkg::LEN_MAX;
      if (src >= 4'(awsp_pkg::N_BUILTIN) && src < 4'(awsp_pkg::N_BUILTIN + awsp_pkg::N_USER)) begin
         play_len = user_len[2'(src - 4'(awsp_pkg::N_BUILTIN))];
      end else if (src == 4'(awsp_pkg::N_BUILTIN + awsp_pkg::N_USER)) begin
         play_len = st.len;
      end
   end
   // Phase plus offset scaled to the record length
   assign ph = st.acc + st.phase_off;
   assign prod = 46'(ph) * 46'(play_len);
   assign rd_idx = (st.mode == awsp_pkg::AWSP_COPY) ? st.cp_idx : prod[45:32];
   assign rd_stage = stage_mem[rd_idx];
   assign rd_user = user_mem[2'(src - 4'(awsp_pkg::N_BUILTIN))][rd_idx];
   assign rd_built = builtin(src[2:0], rd_idx);
   always_comb begin
      if (src < 4'(awsp_pkg::N_BUILTIN)) begin
         sample_code = rd_built;
      end else if (src < 4'(awsp_pkg::N_BUILTIN + awsp_pkg::N_USER)) begin
         sample_code = rd_user;
      end else begin
         sample_code = rd_stage;
      end
   end
   // Memory writes and copy to user slot
   always_ff @(posedge aclk) begin
      if (st.wr_en) begin
         stage_mem[st.wr_idx] <= st.wr_code;
      end
      if (st.mode == awsp_pkg::AWSP_COPY) begin
         user_mem[st.cp_slot][st.cp_idx] <= rd_stage;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < awsp_pkg::N_USER; k++) begin
            user_len[k] <= awsp_pkg::LEN_MAX;
         end
      end else if (st.mode == awsp_pkg::AWSP_COPY && st.cp_idx == 14'h0000) begin
         user_len[st.cp_slot] <= st.len;
      end
   end
   always_comb begin
      logic [31:0] w;
      logic [15:0] h;
      logic [11:0] code;
      logic trig_edge, sw_trig, line_hit;
      logic [LW-1:0] line;
      w = 32'h0;
      h = 16'h0;
      code = 12'h0;
      trig_edge = 1'b0;
      sw_trig = 1'b0;
      line = st.ctrl[awsp_pkg::C_LINE_LO +: LW];
      line_hit = !st.bp_s1[line] && st.bp_prev[line];
      next_st = st;
      next_st.wr_en = 1'b0;
      // Input synchronisers
      next_st.ext_s = {st.ext_s[0], ext_trigger_in};
      next_st.ref_s = {st.ref_s[0], reference_clock_input};
      next_st.bp_s0 = bp_trigger_in;
      next_st.bp_s1 = st.bp_s0;
      next_st.ext_prev = st.ext_s[1];
      next_st.bp_prev = st.bp_s1;
      next_st.ref_prev = st.ref_s[1];
      // AXI write channel
      if (st.awready && s_axi_awvalid) begin
         next_st.awready = 1'b0;
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (st.wready && s_axi_wvalid) begin
         next_st.wready = 1'b0;
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end
      if (st.aw_got && st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = 2'b00;
         for (int b = 0; b < 4; b++) begin
            w[b*8 +: 8] = st.wstrb[b] ? st.wdata[b*8 +: 8] : 8'h00;
         end
         unique case (st.awaddr)
            awsp_pkg::REG_CTRL: next_st.ctrl = w;
            awsp_pkg::REG_LEN: begin
               if (w[13:0] >= awsp_pkg::LEN_MIN && w[13:0] <= awsp_pkg::LEN_MAX && w[31:14] == 18'h0)
                  next_st.len = w[13:0];
               else
                  next_st.bresp = 2'b10;
            end
            awsp_pkg::REG_STEP: next_st.step = w;
            awsp_pkg::REG_PHASE: next_st.phase_off = w;
            awsp_pkg::REG_CYC: next_st.cyc = w;
            awsp_pkg::REG_WADDR: next_st.waddr = w;
            awsp_pkg::REG_WDATA: begin
               h = st.ctrl[awsp_pkg::C_BORD] ? {w[7:0], w[15:8]} : w[15:0];
               if (st.ctrl[awsp_pkg::C_FMT]) begin
                  // Q1.15 fraction to offset binary
                  code = {~h[15], h[14:4]};
               end else begin
                  code = h[11:0] + awsp_pkg::DAC_MID;
               end
               if (st.waddr[13:0] < awsp_pkg::LEN_MAX && (st.ctrl[awsp_pkg::C_FMT]
                   || h[11:0] <= awsp_pkg::BIN_POS_MAX || h[11:0] >= awsp_pkg::BIN_NEG_MIN)) begin
                  next_st.wr_en = 1'b1;
                  next_st.wr_code = code;
                  next_st.wr_idx = st.waddr[13:0];
                  next_st.waddr = st.waddr + 32'h1;
               end else begin
                  next_st.bresp = 2'b10;
               end
            end
            awsp_pkg::REG_CMD: begin
               if (w[awsp_pkg::K_ZERO]) begin
                  next_st.acc = 32'h0;
                  next_st.phase_off = 32'h0;
               end
               if (w[awsp_pkg::K_TRIG]) begin
                  next_st.pulse = 4'hf;
                  sw_trig = 1'b1;
               end
               if (w[awsp_pkg::K_COPY] && st.mode != awsp_pkg::AWSP_COPY) begin
                  next_st.mode = awsp_pkg::AWSP_COPY;
                  next_st.cp_idx = st.len - 14'h1;
                  next_st.cp_slot = w[awsp_pkg::K_SLOT_LO +: 2];
               end
               if (w[awsp_pkg::K_SETUP]) begin
                  // Clear user enable, burst and event source
                  next_st.ctrl[awsp_pkg::C_BURST] = 1'b0;
                  next_st.ctrl[awsp_pkg::C_EVT_LO +: 2] = awsp_pkg::EVT_IMM;
                  next_st.ctrl[awsp_pkg::C_USER] = 1'b0;
               end
            end
            default: next_st.bresp = 2'b10;
         endcase
      end
      // AXI read channel
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end
      if (st.arready && s_axi_arvalid) begin
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp = 2'b00;
         unique case (s_axi_araddr)
            awsp_pkg::REG_CTRL: next_st.rdata = st.ctrl;
            awsp_pkg::REG_LEN: next_st.rdata = {18'h0, st.len};
            awsp_pkg::REG_STEP: next_st.rdata = st.step;
            awsp_pkg::REG_PHASE: next_st.rdata = st.phase_off;
            awsp_pkg::REG_CYC: next_st.rdata = st.cyc;
            awsp_pkg::REG_WADDR: next_st.rdata = st.waddr;
            awsp_pkg::REG_STAT: next_st.rdata = {16'h0, st.dac, st.locked, st.bursting,
                                               st.mode == awsp_pkg::AWSP_COPY,
                                               st.mode == awsp_pkg::AWSP_RUN};
            default: begin
               next_st.rdata = 32'h0;
               next_st.rresp = 2'b10;
            end
         endcase
      end
      // Reference divider and lock
      if (st.ref_cnt == awsp_pkg::REF_HALF_M1) begin
         next_st.ref_cnt = 3'h0;
         next_st.ref_out = ~st.ref_out;
      end else begin
         next_st.ref_cnt = st.ref_cnt + 3'h1;
      end
      if (st.ctrl[awsp_pkg::C_LOCK] && st.ref_s[1] && !st.ref_prev) begin
         // Realign only by stretching
         next_st.ref_cnt = 3'h0;
         next_st.ref_out = st.ref_out || st.ref_cnt == awsp_pkg::REF_HALF_M1;
         next_st.locked = 1'b1;
      end
      if (!st.ctrl[awsp_pkg::C_LOCK]) begin
         next_st.locked = 1'b0;
      end
      // Trigger qualification
      unique case (st.ctrl[awsp_pkg::C_EVT_LO +: 2])
         awsp_pkg::EVT_IMM: trig_edge = 1'b1;
         awsp_pkg::EVT_EXT: trig_edge = st.ext_s[1] && !st.ext_prev;
         awsp_pkg::EVT_BP: trig_edge = line_hit;
         awsp_pkg::EVT_SW: trig_edge = sw_trig;
      endcase
      // Outgoing trigger pulse and backplane drive, ground true
      next_st.pulse = (next_st.pulse != 4'h0 && !sw_trig) ? st.pulse - 4'h1 : next_st.pulse;
      next_st.bp_oe = '0;
      if (st.ctrl[awsp_pkg::C_BPDRV]) begin
         next_st.bp_oe[line] = st.pulse != 4'h0;
      end
      // Playback
      unique case (st.mode)
         awsp_pkg::AWSP_IDLE: begin
            next_st.dac = awsp_pkg::DAC_MID;
            next_st.bursting = 1'b0;
            if (st.ctrl[awsp_pkg::C_USER]) begin
               if (!st.ctrl[awsp_pkg::C_BURST]) begin
                  next_st.mode = awsp_pkg::AWSP_RUN;
               end else if (trig_edge) begin
                  next_st.mode = awsp_pkg::AWSP_RUN;
                  next_st.bursting = 1'b1;
                  next_st.cyc_left = st.cyc;
                  next_st.acc = 32'h0;
               end
            end
         end
         awsp_pkg::AWSP_RUN: begin
            next_st.dac = sample_code;
            {h[0], next_st.acc} = {1'b0, st.acc} + {1'b0, st.step};
            if (!st.ctrl[awsp_pkg::C_USER] || (!st.ctrl[awsp_pkg::C_BURST] && st.bursting)) begin
               next_st.mode = awsp_pkg::AWSP_IDLE;
            end else if (st.bursting && h[0] && st.cyc != 32'h0) begin
               next_st.cyc_left = st.cyc_left - 32'h1;
               if (st.cyc_left == 32'h1) begin
                  next_st.mode = awsp_pkg::AWSP_IDLE;
               end
            end
         end
         awsp_pkg::AWSP_COPY: begin
            next_st.cp_idx = st.cp_idx - 14'h1;
            if (st.cp_idx == 14'h0000) begin
               next_st.mode = awsp_pkg::AWSP_IDLE;
            end
         end
      endcase
      if (!aresetn) begin
         next_st = '0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
         next_st.arready = 1'b1;
         next_st.len = awsp_pkg::LEN_MAX;
         next_st.step = awsp_pkg::NCO_STEP_RST;
         next_st.cyc = awsp_pkg::CYC_RST;
         next_st.dac = awsp_pkg::DAC_MID;
         next_st.mode = awsp_pkg::AWSP_IDLE;
      end
   end
   always_ff @(posedge aclk) begin
      st <= next_st;
   end
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;
   assign bp_trigger_out = '0;
   assign bp_trigger_oe = st.bp_oe;
   assign ext_trigger_out = st.pulse[3];
   assign reference_clock_output = st.ref_out;
   assign ref_locked = st.locked;
   assign dac_code = st.dac;
endmodule

// >>> testbench/awsp_core_assertions.sv
// Checker for the playback core, bound to its ports
module awsp_chk #(
   parameter int BP_LINES = 8
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Address valid
   input wire logic s_axi_awready, // Address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic s_axi_wvalid, // Data valid
   input wire logic s_axi_wready, // Data ready
   input wire logic [1:0] s_axi_bresp, // Response
   input wire logic s_axi_bvalid, // Response valid
   input wire logic [BP_LINES-1:0] bp_trigger_out, // Line level
   input wire logic [BP_LINES-1:0] bp_trigger_oe, // Line enable
   input wire logic ext_trigger_out, // Trigger out
   input wire logic reference_clock_output, // Reference out
   input wire logic [11:0] dac_code // Sample
);
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [31:0] ctl_q;
   logic [2:0] idle_n;
   logic take;
   logic len_bad;
   assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign len_bad = w_q < 32'(awsp_pkg::LEN_MIN) || w_q > 32'(awsp_pkg::LEN_MAX);
   // Track the last write and the control word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 8'h00;
         w_q <= 32'h0;
         ctl_q <= 32'h0;
         idle_n <= 3'h0;
      end else begin
         if (take) begin
            aw_q <= s_axi_awaddr;
            w_q <= s_axi_wdata;
         end
         if (take && s_axi_awaddr == awsp_pkg::REG_CTRL) begin
            ctl_q <= s_axi_wdata;
         end else if (take && s_axi_awaddr == awsp_pkg::REG_CMD && s_axi_wdata[3]) begin
            ctl_q[0] <= 1'b0;
         end
         idle_n <= ctl_q[0] ? 3'h0 : (idle_n == 3'h7 ? idle_n : idle_n + 3'h1);
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_hold4;
      $stable(reference_clock_output) [*4];
   endsequence
   AST_LEN_REFUSE: assert property (s_axi_bvalid && aw_q == awsp_pkg::REG_LEN && len_bad
      |-> s_axi_bresp == 2'h2) else $error("length outside limits accepted");
   AST_LEN_ACCEPT: assert property (s_axi_bvalid && aw_q == awsp_pkg::REG_LEN && !len_bad
      |-> s_axi_bresp == 2'h0) else $error("legal length refused");
   AST_CODE_REFUSE: assert property (s_axi_bvalid && aw_q == awsp_pkg::REG_WDATA
      && ctl_q[3:2] == 2'h0 && w_q[15:0] == 16'h0800 |-> s_axi_bresp == 2'h2)
      else $error("binary code out of range accepted");
   AST_DAC_IDLE: assert property (idle_n == 3'h7 |-> dac_code == awsp_pkg::DAC_MID)
      else $error("output moved without user shape");
   AST_REF_HALF: assert property ($changed(reference_clock_output) |=> s_hold4)
      else $error("reference half period short");
   AST_OE_ONE: assert property ($onehot0(bp_trigger_oe))
      else $error("more than one backplane line driven");
   AST_BP_GND: assert property (bp_trigger_out == '0)
      else $error("backplane drive level not low");
   AST_TRIG_PULSE: assert property ($rose(ext_trigger_out) |-> ##[1:20] !ext_trigger_out)
      else $error("trigger output not a pulse");
endmodule

bind awsp_core awsp_chk #(.BP_LINES(BP_LINES)) i_awsp_chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .bp_trigger_out, .bp_trigger_oe, .ext_trigger_out, .reference_clock_output,
   .dac_code);

// >>> testbench/awsp_host.sv
// Host controller model: AXI4-Lite master for the register port
module awsp_host (
   input wire logic aclk, // Clock
   output logic [7:0] s_axi_awaddr, // Write address
   output logic s_axi_awvalid, // Address valid
   input wire logic s_axi_awready, // Address ready
   output logic [31:0] s_axi_wdata, // Write data
   output logic [3:0] s_axi_wstrb, // Strobes
   output logic s_axi_wvalid, // Data valid
   input wire logic s_axi_wready, // Data ready
   input wire logic [1:0] s_axi_bresp, // Response
   input wire logic s_axi_bvalid, // Response valid
   output logic s_axi_bready, // Response ready
   output logic [7:0] s_axi_araddr, // Read address
   output logic s_axi_arvalid, // Address valid
   input wire logic s_axi_arready, // Address ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic s_axi_rvalid, // Read valid
   output logic s_axi_rready // Read ready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end
   // Each channel released at its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
endmodule

// >>> testbench/tb_awsp_core.sv
// Self-checking bench for the waveform store and playback core
module tb_awsp_core;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 0, aresetn = 0, ext_trigger_in = 0, reference_clock_input = 0;
   logic [7:0] bp_trigger_in = 8'hff, bp_trigger_out, bp_trigger_oe, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic ext_trigger_out, reference_clock_output, ref_locked;
   logic [11:0] dac_code;
   logic [2:0] rc = 3'h0;
   int fails = 0, check_count = 0;
   awsp_core i_awsp_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger_in, .bp_trigger_in,
      .bp_trigger_out, .bp_trigger_oe, .ext_trigger_out, .reference_clock_input,
      .reference_clock_output, .ref_locked, .dac_code);
   awsp_host i_awsp_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   initial forever #5 aclk = ~aclk;
   // Reference source at a tenth of the clock rate
   always @(posedge aclk) begin
      rc <= (rc == 3'h4) ? 3'h0 : rc + 3'h1;
      if (rc == 3'h4) reference_clock_input <= !reference_clock_input;
   end
   task automatic complete_run;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic [1:0] r;
      i_awsp_host.wr(a, d, r);
      chk("bresp", 32'(r), 32'(e));
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] x;
      i_awsp_host.rd(a, d, x);
      chk("rresp", 32'(x), 32'(er));
      chk("rdata", d & m, e);
   endtask
   // Bounded status poll
   task automatic ws(input logic [31:0] m, e);
      logic [31:0] d;
      logic [1:0] x;
      for (int i = 0; i < 200; i++) begin
         i_awsp_host.rd(awsp_pkg::REG_STAT, d, x);
         if ((d & m) === e) break;
      end
      chk("status", d & m, e);
   endtask
   // Capture two periods and check the second repeats the first
   task automatic t_period(input int p);
      logic [11:0] d [64];
      repeat (20) @(posedge aclk);
      for (int i = 0; i < 2 * p; i++) begin
         @(posedge aclk);
         d[i] = dac_code;
      end
      chk("moving", 32'(d[0] !== d[2]), 32'h1);
      for (int i = 0; i < p; i++) chk("period", 32'(d[i + p]), 32'(d[i]));
   endtask
   task automatic t_regs;
      chk("dac_reset", 32'(dac_code), 32'h800);
      r(awsp_pkg::REG_LEN, 32'hffff_ffff, 32'h3e80, 2'h0);
      r(awsp_pkg::REG_CYC, 32'hffff_ffff, 32'h1, 2'h0);
      w(awsp_pkg::REG_LEN, 32'h7, 2'h2);
      w(awsp_pkg::REG_LEN, 32'h3e81, 2'h2);
      r(awsp_pkg::REG_LEN, 32'hffff_ffff, 32'h3e80, 2'h0);
      w(awsp_pkg::REG_LEN, 32'h8, 2'h0);
      w(8'h24, 32'h0, 2'h2);
      r(awsp_pkg::REG_CMD, 32'hffff_ffff, 32'h0, 2'h2);
      w(awsp_pkg::REG_PHASE, 32'h4000_0000, 2'h0);
      r(awsp_pkg::REG_PHASE, 32'hffff_ffff, 32'h4000_0000, 2'h0);
      w(awsp_pkg::REG_CMD, 32'h1, 2'h0);
      r(awsp_pkg::REG_PHASE, 32'hffff_ffff, 32'h0, 2'h0);
      $display("t_regs done");
   endtask
   task automatic t_samples;
      w(awsp_pkg::REG_WADDR, 32'h0, 2'h0);
      w(awsp_pkg::REG_WDATA, 32'h0800, 2'h2);
      w(awsp_pkg::REG_WDATA, 32'h0801, 2'h0);
      w(awsp_pkg::REG_CTRL, 32'h4, 2'h0);
      w(awsp_pkg::REG_WDATA, 32'h0008, 2'h2);
      w(awsp_pkg::REG_WDATA, 32'h0800, 2'h0);
      w(awsp_pkg::REG_CTRL, 32'h8, 2'h0);
      w(awsp_pkg::REG_WDATA, 32'h8000, 2'h0);
      w(awsp_pkg::REG_WDATA, 32'h7fff, 2'h0);
      w(awsp_pkg::REG_CTRL, 32'h900, 2'h0);
      w(awsp_pkg::REG_WADDR, 32'h0, 2'h0);
      for (int i = 0; i < 8; i++) w(awsp_pkg::REG_WDATA, 32'(i * 256), 2'h0);
      $display("t_samples done");
   endtask
   task automatic t_play;
      w(awsp_pkg::REG_STEP, 32'h2000_0000, 2'h0);
      repeat (30) @(posedge aclk);
      chk("idle_dac", 32'(dac_code), 32'h800);
      w(awsp_pkg::REG_CTRL, 32'h901, 2'h0);
      t_period(8);
      w(awsp_pkg::REG_STEP, 32'h1000_0000, 2'h0);
      t_period(16);
      w(awsp_pkg::REG_CMD, 32'h14, 2'h0);
      ws(32'h2, 32'h0);
      w(awsp_pkg::REG_CTRL, 32'h601, 2'h0);
      t_period(16);
      for (int k = 0; k < 5; k++) begin
         w(awsp_pkg::REG_CTRL, 32'(k * 256 + 1), 2'h0);
         r(awsp_pkg::REG_STAT, 32'h1, 32'h1, 2'h0);
      end
      w(awsp_pkg::REG_CTRL, 32'h1903, 2'h0);
      w(awsp_pkg::REG_CMD, 32'h8, 2'h0);
      r(awsp_pkg::REG_CTRL, 32'h3f03, 32'h0900, 2'h0);
      $display("t_play done");
   endtask
   task automatic t_ref;
      int n;
      logic p;
      n = 0;
      w(awsp_pkg::REG_CTRL, 32'h20, 2'h0);
      ws(32'h8, 32'h8);
      chk("locked", 32'(ref_locked), 32'h1);
      repeat (30) @(posedge aclk);
      for (int i = 0; i < 100; i++) begin
         p = reference_clock_output;
         @(posedge aclk);
         n += int'(reference_clock_output != p);
      end
      chk("ref_edges", 32'(n), 32'd20);
      $display("t_ref done");
   endtask
   task automatic t_burst;
      w(awsp_pkg::REG_CYC, 32'h0, 2'h0);
      w(awsp_pkg::REG_CTRL, 32'h0004_2913, 2'h0);
      r(awsp_pkg::REG_STAT, 32'h4, 32'h0, 2'h0);
      bp_trigger_in <= 8'hef;
      ws(32'h4, 32'h4);
      repeat (200) @(posedge aclk);
      r(awsp_pkg::REG_STAT, 32'h4, 32'h4, 2'h0);
      bp_trigger_in <= 8'hff;
      w(awsp_pkg::REG_CMD, 32'h2, 2'h0);
      for (int i = 0; i < 30 && ext_trigger_out !== 1'b1; i++) @(posedge aclk);
      chk("trig_out", 32'(ext_trigger_out), 32'h1);
      @(posedge aclk);
      chk("oe", 32'(bp_trigger_oe), 32'h10);
      w(awsp_pkg::REG_CTRL, 32'h0, 2'h0);
      w(awsp_pkg::REG_CYC, 32'd20, 2'h0);
      w(awsp_pkg::REG_CTRL, 32'h1903, 2'h0);
      ws(32'h4, 32'h0);
      ext_trigger_in <= 1'b1;
      ws(32'h4, 32'h4);
      ws(32'h4, 32'h0);
      ext_trigger_in <= 1'b0;
      repeat (50) @(posedge aclk);
      r(awsp_pkg::REG_STAT, 32'h4, 32'h0, 2'h0);
      $display("t_burst done");
   endtask
   initial begin
      repeat (40000) @(posedge aclk);
      fails++;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_samples;
      t_play;
      t_ref;
      t_burst;
      complete_run;
   end
endmodule
